// ==== design/option_cfg_pkg.sv ====
package option_cfg_pkg;
    // Avalon word byte addresses
    localparam logic [3:0] clock_watchdog_options_addr = 4'h0;
    localparam logic [3:0] wakeup_clock_options_addr = 4'h1;
    localparam logic [3:0] crystal_settle_time_addr = 4'h2;
    localparam logic [3:0] reserved_option_addr = 4'h3;
    localparam logic [3:0] flash_wait_option_addr = 4'h4;
    localparam logic [3:0] boot_loader_option_addr = 4'h5;
    localparam logic [3:0] load_status_addr = 4'h6;
    localparam logic [3:0] apply_ctrl_addr = 4'h7;
    localparam logic [3:0] last_addr = 4'h7;
    localparam int option_count = 6;
    // Field positions, clock_watchdog_options
    localparam int slow_rc_cpu_allow_bit = 0;
    localparam int indep_dog_hw_start_bit = 1;
    localparam int window_dog_hw_start_bit = 2;
    localparam int window_dog_halt_reset_bit = 3;
    localparam int ext_clock_select_bit = 4;
    // Field positions, wakeup_clock_options
    localparam int wakeup_clock_select_bit = 2;
    localparam int wakeup_prescale_lo = 0;
    // Field position, flash_wait_option
    localparam int flash_wait_insert_bit = 0;
    // Reset values
    localparam logic [7:0] option_reset = 8'h00;
    // Settle codes and half-cycle counts
    localparam logic [7:0] settle_code_2048 = 8'h00;
    localparam logic [7:0] settle_code_128 = 8'hb4;
    localparam logic [7:0] settle_code_8 = 8'hd2;
    localparam logic [7:0] settle_code_half = 8'he1;
    localparam logic [12:0] settle_half_2048 = 13'h1000;
    localparam logic [12:0] settle_half_128 = 13'h0100;
    localparam logic [12:0] settle_half_8 = 13'h0010;
    localparam logic [12:0] settle_half_half = 13'h0001;
    // Wakeup prescale divide ratios to 128 kHz
    localparam logic [7:0] wakeup_div_24m = 8'hbc;
    localparam logic [7:0] wakeup_div_16m = 8'h7d;
    localparam logic [7:0] wakeup_div_8m = 8'h3f;
    localparam logic [7:0] wakeup_div_4m = 8'h20;
    localparam int slow_rc_khz = 128;
    localparam int flash_wait_limit_mhz = 16;
    // CPU clock source codes: fast RC, external, slow RC
    localparam logic [1:0] cpu_src_fast_rc = 2'h0;
    localparam logic [1:0] cpu_src_external = 2'h1;
    localparam logic [1:0] cpu_src_slow_rc = 2'h2;
endpackage : option_cfg_pkg

// ==== design/option_load_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface option_load_if;
    logic req;
    logic [2:0] index;
    logic valid;
    logic [7:0] data;
    modport loader(output req, output index, input valid, input data);
    modport fetcher(input req, input index, output valid, output data);
endinterface : option_load_if
`default_nettype wire

// ==== design/option_nvm_fetch.sv ====
`timescale 1ns/1ps
`default_nettype none
module option_nvm_fetch (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Loader side
    option_load_if.fetcher ld,
    // Non-volatile memory read port
    output logic o_nvm_rd,
    output logic [2:0] o_nvm_addr,
    input wire logic i_nvm_ack,
    input wire logic [7:0] i_nvm_data
);
    import option_cfg_pkg::*;

    typedef struct packed {
        logic busy;
        logic valid;
        logic [7:0] data;
        logic [2:0] addr;
    } fetch_state_type;

    fetch_state_type state;
    fetch_state_type next_state;

    always_comb begin
        next_state = state;
        next_state.valid = 1'b0;
        if (!state.busy && ld.req) begin
            next_state.busy = 1'b1;
            next_state.addr = ld.index;
        end else if (state.busy && i_nvm_ack) begin
            next_state.busy = 1'b0;
            next_state.valid = 1'b1;
            next_state.data = i_nvm_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_nvm_rd = state.busy;
    assign o_nvm_addr = state.addr;
    assign ld.valid = state.valid;
    assign ld.data = state.data;
endmodule // option_nvm_fetch
`default_nettype wire

// ==== design/option_byte_config_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Option bit set lets the clock controller pick the slow RC as CPU clock, clear forbids it.
// - Option bit set starts the independent watchdog by hardware, clear leaves it to software.
// - Option bit set starts the window watchdog by hardware, clear leaves it to software.
// - Option bit set makes halt reset the chip while the window watchdog runs, clear never.
// - Option bit clear runs a crystal on both pins, set takes an external clock on the input pin.
// - Option bit clear clocks the wakeup unit from the slow RC, set from the prescaled external clock.
// - Two prescale bits divide 24, 16, 8 or 4 MHz down to 128 kHz for codes 00 to 11.
// - Eight settle bits pick 2048, 128, 8 or 0.5 external cycles before the crystal counts stable.
// - Flash wait bit clear gives no wait state, set gives one on every flash or EEPROM read.
// - The slow RC source named by the options is the 128 kHz internal oscillator.
module option_byte_config_decoder (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // System reset being held, from the reset controller
    input wire logic i_sys_reset_hold,
    // Non-volatile memory read port
    output logic o_nvm_rd,
    output logic [2:0] o_nvm_addr,
    input wire logic i_nvm_ack,
    input wire logic [7:0] i_nvm_data,
    // Avalon-MM slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Decoded configuration
    output logic o_options_ready,
    output logic o_slow_rc_cpu_allow,
    output logic o_indep_dog_hw_start,
    output logic o_window_dog_hw_start,
    output logic o_window_dog_halt_reset,
    output logic o_ext_clock_select,
    output logic o_osc_output_pin_drive,
    output logic o_wakeup_clock_select,
    output logic [1:0] o_wakeup_prescale_sel,
    output logic [7:0] o_wakeup_divider,
    output logic [12:0] o_crystal_settle_halves,
    output logic o_flash_wait_insert,
    output logic [7:0] o_slow_rc_khz
);
    import option_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_fetch = 4'b0010,
        st_wait = 4'b0100,
        st_done = 4'b1000
    } load_state_type;

    typedef struct packed {
        load_state_type fsm;
        logic [2:0] index;
        logic req;
        logic [7:0] byte0;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic [7:0] byte3;
        logic [7:0] byte4;
        logic [7:0] byte5;
        logic pending;
        logic ready;
        logic slow_rc_cpu_allow;
        logic indep_dog_hw_start;
        logic window_dog_hw_start;
        logic window_dog_halt_reset;
        logic ext_clock_select;
        logic osc_drive;
        logic wakeup_clock_select;
        logic [1:0] wakeup_prescale_sel;
        logic [7:0] wakeup_divider;
        logic [12:0] settle_halves;
        logic flash_wait_insert;
        logic [31:0] rdata;
        logic rvalid;
        logic hold_meta;
        logic hold_sync;
        logic hold_sync2;
    } top_state_type;

    top_state_type state;
    top_state_type next_state;
    option_load_if ld ();

    option_nvm_fetch u_fetch (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .ld(ld),
        .o_nvm_rd(o_nvm_rd),
        .o_nvm_addr(o_nvm_addr),
        .i_nvm_ack(i_nvm_ack),
        .i_nvm_data(i_nvm_data)
    );

    assign ld.req = state.req;
    assign ld.index = state.index;

    ////////////////////////////////////////////////////////////////////////////
    // Settle time decode; unlisted codes take the longest wait to stay safe
    function automatic logic [12:0] settle_decode(input logic [7:0] code);
        logic [12:0] halves;
        halves = settle_half_2048;
        case (code)
            settle_code_2048: halves = settle_half_2048;
            settle_code_128: halves = settle_half_128;
            settle_code_8: halves = settle_half_8;
            settle_code_half: halves = settle_half_half;
            default: halves = settle_half_2048;
        endcase
        return halves;
    endfunction

    function automatic logic [7:0] prescale_decode(input logic [1:0] sel);
        logic [7:0] div;
        div = wakeup_div_24m;
        case (sel)
            2'h0: div = wakeup_div_24m;
            2'h1: div = wakeup_div_16m;
            2'h2: div = wakeup_div_8m;
            2'h3: div = wakeup_div_4m;
            default: div = wakeup_div_24m;
        endcase
        return div;
    endfunction

    function automatic logic [7:0] option_byte(input top_state_type s, input logic [2:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            3'h0: v = s.byte0;
            3'h1: v = s.byte1;
            3'h2: v = s.byte2;
            3'h3: v = s.byte3;
            3'h4: v = s.byte4;
            3'h5: v = s.byte5;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic bus_hit;
    logic [7:0] wbyte;

    always_comb begin
        next_state = state;
        next_state.req = 1'b0;
        next_state.rvalid = 1'b0;
        // Hold comes from another reset domain, so synchronise it
        next_state.hold_meta = i_sys_reset_hold;
        next_state.hold_sync = state.hold_meta;
        next_state.hold_sync2 = state.hold_sync;
        bus_hit = i_avs_address <= last_addr;
        wbyte = i_avs_writedata[7:0];

        // Loader: fetch each option byte in turn while reset is held
        case (state.fsm)
            st_idle: begin
                if (state.hold_sync && state.hold_sync2) begin
                    next_state.fsm = st_fetch;
                    next_state.index = 3'h0;
                    next_state.ready = 1'b0;
                end
            end
            st_fetch: begin
                next_state.req = 1'b1;
                next_state.fsm = st_wait;
            end
            st_wait: begin
                if (ld.valid) begin
                    case (state.index)
                        3'h0: next_state.byte0 = ld.data;
                        3'h1: next_state.byte1 = ld.data;
                        3'h2: next_state.byte2 = ld.data;
                        3'h3: next_state.byte3 = ld.data;
                        3'h4: next_state.byte4 = ld.data;
                        default: next_state.byte5 = ld.data;
                    endcase
                    if (state.index == 3'(option_count - 1)) begin
                        next_state.fsm = st_done;
                    end else begin
                        next_state.index = state.index + 3'h1;
                        next_state.fsm = st_fetch;
                    end
                end
            end
            st_done: begin
                // Apply only after reset release, then freeze until next hold
                if (!state.hold_sync && !state.hold_sync2) begin
                    next_state.pending = 1'b1;
                    next_state.fsm = st_idle;
                end
            end
            default: next_state.fsm = st_idle;
        endcase

        // Software copy writes only change the read-back bytes; the next hold reloads them from memory
        if (i_avs_write && bus_hit && i_avs_byteenable[0] && state.fsm == st_idle) begin
            case (i_avs_address)
                clock_watchdog_options_addr: next_state.byte0 = wbyte;
                wakeup_clock_options_addr: next_state.byte1 = wbyte;
                crystal_settle_time_addr: next_state.byte2 = wbyte;
                flash_wait_option_addr: next_state.byte4 = wbyte;
                boot_loader_option_addr: next_state.byte5 = wbyte;
                default: next_state.byte3 = state.byte3;
            endcase
        end

        if (state.pending) begin
            next_state.pending = 1'b0;
            next_state.ready = 1'b1;
            next_state.slow_rc_cpu_allow = state.byte0[slow_rc_cpu_allow_bit];
            next_state.indep_dog_hw_start = state.byte0[indep_dog_hw_start_bit];
            next_state.window_dog_hw_start = state.byte0[window_dog_hw_start_bit];
            next_state.window_dog_halt_reset = state.byte0[window_dog_halt_reset_bit];
            next_state.ext_clock_select = state.byte0[ext_clock_select_bit];
            next_state.osc_drive = !state.byte0[ext_clock_select_bit];
            next_state.wakeup_clock_select = state.byte1[wakeup_clock_select_bit];
            next_state.wakeup_prescale_sel = state.byte1[wakeup_prescale_lo +: 2];
            next_state.wakeup_divider = prescale_decode(state.byte1[wakeup_prescale_lo +: 2]);
            next_state.settle_halves = settle_decode(state.byte2);
            next_state.flash_wait_insert = state.byte4[flash_wait_insert_bit];
        end

        // Reads answer one cycle after the request
        if (i_avs_read && !state.rvalid) begin
            next_state.rvalid = 1'b1;
            next_state.rdata = 32'h0;
            if (i_avs_address < 4'(option_count)) begin
                next_state.rdata = {24'h0, option_byte(state, i_avs_address[2:0])};
            end else if (i_avs_address == load_status_addr) begin
                next_state.rdata = {28'h0, state.fsm};
                next_state.rdata[31] = state.ready;
            end else if (i_avs_address == apply_ctrl_addr) begin
                next_state.rdata = {31'h0, state.pending};
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state <= '0;
            state.fsm <= st_idle;
            state.settle_halves <= settle_half_2048;
            state.wakeup_divider <= wakeup_div_24m;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reads wait one cycle; writes complete at once
    assign o_avs_waitrequest = i_avs_read && !state.rvalid;
    assign o_avs_readdata = state.rdata;
    assign o_options_ready = state.ready;
    assign o_slow_rc_cpu_allow = state.slow_rc_cpu_allow;
    assign o_indep_dog_hw_start = state.indep_dog_hw_start;
    assign o_window_dog_hw_start = state.window_dog_hw_start;
    assign o_window_dog_halt_reset = state.window_dog_halt_reset;
    assign o_ext_clock_select = state.ext_clock_select;
    assign o_osc_output_pin_drive = state.osc_drive;
    assign o_wakeup_clock_select = state.wakeup_clock_select;
    assign o_wakeup_prescale_sel = state.wakeup_prescale_sel;
    assign o_wakeup_divider = state.wakeup_divider;
    assign o_crystal_settle_halves = state.settle_halves;
    assign o_flash_wait_insert = state.flash_wait_insert;
    assign o_slow_rc_khz = 8'(slow_rc_khz);
endmodule // option_byte_config_decoder
`default_nettype wire

// ==== tb/nvm_option_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module nvm_option_model (
    // Clock
    input wire logic i_ref_clk,
    // Loader read port
    input wire logic i_nvm_rd,
    input wire logic [2:0] i_nvm_addr,
    input wire logic i_slow,
    output logic o_nvm_ack,
    output logic [7:0] o_nvm_data
);
    logic [7:0] mem [6];
    int wait_cnt = 0;
    initial o_nvm_ack = 1'b0;
    initial o_nvm_data = 8'h00;
    always @(posedge i_ref_clk) begin
        o_nvm_ack <= 1'b0;
        if (i_nvm_rd && !o_nvm_ack && wait_cnt >= (i_slow ? 4 : 0)) begin
            o_nvm_ack <= 1'b1;
            o_nvm_data <= mem[i_nvm_addr];
            wait_cnt <= 0;
        end else begin
            // Released bus inverts the last byte every cycle rather than holding it
            o_nvm_data <= ~o_nvm_data;
            wait_cnt <= i_nvm_rd ? wait_cnt + 1 : 0;
        end
    end
endmodule // nvm_option_model
`default_nettype wire

// ==== tb/option_byte_config_decoder_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module option_byte_config_decoder_asserts (
    // Watched ports
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_sys_reset_hold,
    input wire logic i_nvm_ack,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_nvm_rd,
    input wire logic [2:0] o_nvm_addr,
    input wire logic o_avs_waitrequest,
    input wire logic o_options_ready,
    input wire logic o_slow_rc_cpu_allow,
    input wire logic o_ext_clock_select,
    input wire logic o_osc_output_pin_drive,
    input wire logic [1:0] o_wakeup_prescale_sel,
    input wire logic [7:0] o_wakeup_divider,
    input wire logic [12:0] o_crystal_settle_halves,
    input wire logic o_flash_wait_insert,
    input wire logic [7:0] o_slow_rc_khz
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    // Quiet time since hold, covers the 3-flop sync plus update
    logic [3:0] quiet;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || i_sys_reset_hold) quiet <= 4'h0;
        else if (quiet != 4'hf) quiet <= quiet + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_osc_drive; o_options_ready |-> o_osc_output_pin_drive == !o_ext_clock_select; endproperty
    a_osc_drive: assert property (p_osc_drive) else $error("osc drive not inverse of ext select");
    property p_slow_khz; o_slow_rc_khz == 8'h80; endproperty
    a_slow_khz: assert property (p_slow_khz) else $error("slow rc rate wrong");
    property p_divider;
        o_wakeup_divider == (o_wakeup_prescale_sel == 2'h0 ? 8'hbc : o_wakeup_prescale_sel == 2'h1 ? 8'h7d :
                             o_wakeup_prescale_sel == 2'h2 ? 8'h3f : 8'h20);
    endproperty
    a_divider: assert property (p_divider) else $error("wakeup divider mismatch");
    property p_settle; o_crystal_settle_halves inside {13'h1000, 13'h0100, 13'h0010, 13'h0001}; endproperty
    a_settle: assert property (p_settle) else $error("settle count not a listed value");
    property p_frozen;
        quiet >= 4'ha && o_options_ready |=> $stable({o_slow_rc_cpu_allow, o_ext_clock_select,
            o_wakeup_prescale_sel, o_crystal_settle_halves, o_flash_wait_insert, o_options_ready});
    endproperty
    a_frozen: assert property (p_frozen) else $error("config changed outside reset");
    property p_fetch_hold; o_nvm_rd && !i_nvm_ack |=> o_nvm_rd && $stable(o_nvm_addr); endproperty
    a_fetch_hold: assert property (p_fetch_hold) else $error("fetch dropped before ack");
    property p_fetch_gap; o_nvm_rd && i_nvm_ack |=> !o_nvm_rd; endproperty
    a_fetch_gap: assert property (p_fetch_gap) else $error("fetch not released after ack");
    property p_read_wait; $rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest; endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait not one cycle");
    property p_write_wait; i_avs_write |-> !o_avs_waitrequest; endproperty
    a_write_wait: assert property (p_write_wait) else $error("write stalled");
endmodule // option_byte_config_decoder_asserts
bind option_byte_config_decoder option_byte_config_decoder_asserts u_chk (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_sys_reset_hold(i_sys_reset_hold), .i_nvm_ack(i_nvm_ack), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_nvm_rd(o_nvm_rd), .o_nvm_addr(o_nvm_addr), .o_avs_waitrequest(o_avs_waitrequest),
    .o_options_ready(o_options_ready), .o_slow_rc_cpu_allow(o_slow_rc_cpu_allow),
    .o_ext_clock_select(o_ext_clock_select), .o_osc_output_pin_drive(o_osc_output_pin_drive),
    .o_wakeup_prescale_sel(o_wakeup_prescale_sel), .o_wakeup_divider(o_wakeup_divider),
    .o_crystal_settle_halves(o_crystal_settle_halves), .o_flash_wait_insert(o_flash_wait_insert),
    .o_slow_rc_khz(o_slow_rc_khz));
`default_nettype wire

// ==== tb/option_byte_config_decoder_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module option_byte_config_decoder_tb;
    import option_cfg_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, hold = 1'b0, rd = 1'b0, wr = 1'b0, slow = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, q, v, seed = 32'd97344;
    logic nvm_rd, nvm_ack, waitreq, ready, s_allow, i_dog, w_dog, w_halt, ext, osc_drv, wk_sel, flash;
    logic [2:0] nvm_addr;
    logic [7:0] nvm_data, wk_div, khz;
    logic [1:0] presc;
    logic [12:0] settle;
    logic [31:0] avs_q;
    logic [7:0] b [6];
    int fail_count = 0, check_count = 0, acks = 0;
    int div_tab [4] = '{188, 125, 63, 32};
    logic [7:0] codes [5] = '{8'h00, 8'hb4, 8'hd2, 8'he1, 8'h55};
    always #10 clk = ~clk;
    always @(posedge clk) acks <= acks + int'(nvm_ack);
    option_byte_config_decoder DUT (.i_ref_clk(clk), .i_rstn(rstn), .i_sys_reset_hold(hold), .o_nvm_rd(nvm_rd),
        .o_nvm_addr(nvm_addr), .i_nvm_ack(nvm_ack), .i_nvm_data(nvm_data), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'h1), .o_avs_readdata(avs_q),
        .o_avs_waitrequest(waitreq), .o_options_ready(ready), .o_slow_rc_cpu_allow(s_allow),
        .o_indep_dog_hw_start(i_dog), .o_window_dog_hw_start(w_dog), .o_window_dog_halt_reset(w_halt),
        .o_ext_clock_select(ext), .o_osc_output_pin_drive(osc_drv), .o_wakeup_clock_select(wk_sel),
        .o_wakeup_prescale_sel(presc), .o_wakeup_divider(wk_div), .o_crystal_settle_halves(settle),
        .o_flash_wait_insert(flash), .o_slow_rc_khz(khz));
    nvm_option_model nvm (.i_ref_clk(clk), .i_nvm_rd(nvm_rd), .i_nvm_addr(nvm_addr), .i_slow(slow),
        .o_nvm_ack(nvm_ack), .o_nvm_data(nvm_data));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int settle_of(logic [7:0] c);
        case (c)
            8'hb4: return 256;
            8'hd2: return 16;
            8'he1: return 1;
            default: return 4096;
        endcase
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Held until waitrequest is sampled low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        addr <= a; rd <= !w; wr <= w; wdata <= d;
        @(posedge clk);
        while (waitreq !== 1'b0 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k == 50) fail_count++;
        rdata = avs_q;
        rd <= 1'b0; wr <= 1'b0;
    endtask
    task automatic verify();
        check(ready, 1);
        check(s_allow, b[0][0]);
        check(i_dog, b[0][1]);
        check(w_dog, b[0][2]);
        check(w_halt, b[0][3]);
        check({osc_drv, ext}, {!b[0][4], b[0][4]});
        check(wk_sel, b[1][2]);
        check(wk_div, div_tab[b[1][1:0]]);
        check(presc, b[1][1:0]);
        check(settle, settle_of(b[2]));
        check(flash, b[4][0]);
        check(khz, 128);
    endtask
    // One option load, prompt or slow memory, bytes random
    task automatic load(input int k);
        int start, t;
        for (int i = 0; i < 6; i++) b[i] = rnd();
        b[1][1:0] = k[1:0];
        b[2] = codes[k];
        // A 24 MHz input needs a flash wait state
        if (k[1:0] == 2'h0) b[4][0] = 1'b1;
        for (int i = 0; i < 6; i++) nvm.mem[i] = b[i];
        start = acks;
        t = 0;
        @(posedge clk);
        hold <= 1'b1;
        slow <= k[0];
        while (acks - start < 6 && t < 400) begin
            @(posedge clk);
            t++;
        end
        if (t == 400) fail_count++;
        @(posedge clk);
        hold <= 1'b0;
        repeat (7) @(posedge clk);
        verify();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int k = 0; k < 5; k++) load(k);
        for (int i = 0; i < 6; i++) begin
            if (i != 3) begin
                bus(1'b0, 4'(i), 32'h0);
                check(rdata[7:0], b[i]);
            end
        end
        bus(1'b0, 4'h6, 32'h0);
        check({rdata[31], rdata[30:4]}, {1'b1, 27'h0});
        bus(1'b0, 4'h7, 32'h0);
        check(rdata, 0);
        bus(1'b0, 4'h9, 32'h0);
        check(rdata, 0);
        v = rnd();
        bus(1'b1, 4'h0, {24'h0, v[7:0]});
        bus(1'b0, 4'h0, 32'h0);
        check(rdata[7:0], v[7:0]);
        verify();
        bus(1'b0, 4'h3, 32'h0);
        q = rdata;
        bus(1'b1, 4'h3, ~q);
        bus(1'b0, 4'h3, 32'h0);
        check(rdata, q);
        close_out();
    end
    // Loads need a few hundred cycles; this is ample
    initial begin
        #400000;
        fail_count++;
        close_out();
    end
endmodule // option_byte_config_decoder_tb
`default_nettype wire
